// >>> rtl/lcdhi_device.sv
// Device end of the LCD driver host link with scan order outputs
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module lcdhi_device #(
	parameter int COM_N = 17,
	parameter int SEG_N = 100
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	// Link pins
	lcdhi_if.dev                  link,
	// Mode
	input  wire logic             i_nibble_mode,
	output logic                  o_serial_mode,
	// Register write
	output logic                  o_wr_valid,
	output logic [1:0]            o_wr_sel,
	output logic [7:0]            o_wr_data,
	// Register read
	output logic [1:0]            o_rd_sel,
	output logic                  o_rd_taken,
	input  wire logic [7:0]       i_rd_data,
	// Scan outputs
	input  wire logic [7:0]       i_com_row,
	input  wire logic [SEG_N-1:0] i_seg_data,
	output logic [COM_N-1:0]      o_com,
	output logic [SEG_N-1:0]      o_seg
);
	import lcdhi_pkg::*;

	logic [SV_W-1:0] s1_q;
	logic [SV_W-1:0] s2_q;
	logic            e_q;
	logic            sht_q;
	logic            nib_q;
	logic [7:0]      hinib_q;
	logic [3:0]      cnt_q;
	logic [7:0]      si_q;
	logic [7:0]      so_q;
	logic            hdr_rw_q;
	logic            sdo_q;
	logic [7:0]      bus_out_q;
	logic [7:0]      bus_oe_q;

	logic       serial;
	logic       e_rise;
	logic       e_fall;
	logic       sht_rise;
	logic       sht_fall;
	logic       cs_act;
	logic [7:0] bus_s;
	logic [1:0] sel_s;

	// Two-flop synchronisers on every pin
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {link.strap_serial, link.rw, link.rs_hi, link.rs_lo, link.e,
				link.cs_n, link.shift_clock, link.sdi, link.common_scan_reverse,
				link.segment_scan_reverse, link.host_bus_lines};
			s2_q <= s1_q;
		end
	end

	assign serial   = (s2_q[SV_STRAP] == LINK_SERIAL);
	assign bus_s    = s2_q[7:0];
	assign sel_s    = {s2_q[SV_RSH], s2_q[SV_RSL]};
	assign e_rise   = !serial && s2_q[SV_E] && !e_q;
	assign e_fall   = !serial && !s2_q[SV_E] && e_q;
	assign cs_act   = serial && !s2_q[SV_CSN];
	assign sht_rise = cs_act && s2_q[SV_SHT] && !sht_q;
	assign sht_fall = cs_act && !s2_q[SV_SHT] && sht_q;

	// Edge history
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			e_q   <= 1'b0;
			sht_q <= 1'b1;
		end else begin
			e_q   <= s2_q[SV_E];
			sht_q <= s2_q[SV_SHT];
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_serial_mode <= 1'b0;
		end else begin
			o_serial_mode <= serial;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			nib_q   <= 1'b0;
			hinib_q <= BYTE_RESET;
		end else if (serial || !i_nibble_mode) begin
			nib_q <= 1'b0;
		end else if (e_fall) begin
			nib_q <= !nib_q;
			if (!nib_q) begin
				hinib_q <= {bus_s[7:4], 4'h0};
			end
		end
	end

	// Serial frame receive
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_q    <= 4'h0;
			si_q     <= BYTE_RESET;
			hdr_rw_q <= DIR_WRITE;
		end else if (!cs_act) begin
			cnt_q <= 4'h0;
		end else if (sht_rise && cnt_q != SER_FRAME_BITS) begin
			cnt_q <= cnt_q + 4'h1;
			si_q  <= {si_q[6:0], s2_q[SV_SDI]};
			if (cnt_q == 4'h0) begin
				hdr_rw_q <= s2_q[SV_SDI];
			end
		end
	end

	// Register write strobe
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_wr_valid <= 1'b0;
			o_wr_sel   <= SEL_EXPAN;
			o_wr_data  <= BYTE_RESET;
		end else begin
			o_wr_valid <= 1'b0;
			if (e_fall && s2_q[SV_RW] == DIR_WRITE) begin
				if (!i_nibble_mode) begin
					o_wr_valid <= 1'b1;
					o_wr_sel   <= sel_s;
					o_wr_data  <= bus_s;
				end else if (nib_q) begin
					o_wr_valid <= 1'b1;
					o_wr_sel   <= sel_s;
					o_wr_data  <= {hinib_q[7:4], bus_s[7:4]};
				end
			end else if (sht_rise && cnt_q == SER_FRAME_BITS - 4'h1
				&& hdr_rw_q == DIR_WRITE) begin
				o_wr_valid <= 1'b1;
				o_wr_sel   <= o_rd_sel;
				o_wr_data  <= {si_q[6:0], s2_q[SV_SDI]};
			end
		end
	end

	// Read select and taken pulse
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rd_sel   <= SEL_EXPAN;
			o_rd_taken <= 1'b0;
		end else begin
			o_rd_taken <= 1'b0;
			if (e_rise) begin
				o_rd_sel <= sel_s;
			end else if (sht_rise && cnt_q == SER_HDR_BITS - 4'h1) begin
				o_rd_sel <= {si_q[0], s2_q[SV_SDI]};
			end
			if (e_fall && s2_q[SV_RW] == DIR_READ && !(i_nibble_mode && !nib_q)) begin
				o_rd_taken <= 1'b1;
			end else if (sht_rise && cnt_q == SER_FRAME_BITS - 4'h1
				&& hdr_rw_q == DIR_READ) begin
				// Last rise ends a read frame; the host deselects before any fall
				o_rd_taken <= 1'b1;
			end
		end
	end

	// Parallel read drive while strobe high
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bus_out_q <= BYTE_RESET;
			bus_oe_q  <= 8'h00;
		end else if (!serial && s2_q[SV_E] && e_q && s2_q[SV_RW] == DIR_READ) begin
			if (i_nibble_mode) begin
				bus_out_q <= {nib_q ? i_rd_data[3:0] : i_rd_data[7:4], 4'h0};
				bus_oe_q  <= 8'hF0;
			end else begin
				bus_out_q <= i_rd_data;
				bus_oe_q  <= 8'hFF;
			end
		end else begin
			bus_oe_q <= 8'h00;
		end
	end

	// Serial output shifter
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			so_q  <= BYTE_RESET;
			sdo_q <= 1'b0;
		end else if (sht_fall && hdr_rw_q == DIR_READ) begin
			if (cnt_q == SER_HDR_BITS) begin
				sdo_q <= i_rd_data[7];
				so_q  <= {i_rd_data[6:0], 1'b0};
			end else if (cnt_q > SER_HDR_BITS && cnt_q < SER_FRAME_BITS) begin
				sdo_q <= so_q[7];
				so_q  <= {so_q[6:0], 1'b0};
			end
		end
	end

	assign link.sdo       = sdo_q;
	assign link.bus_d_out = bus_out_q;
	assign link.bus_d_oe  = bus_oe_q;

	// Row scan order
	for (genvar k = 0; k < COM_N; k++) begin : g_com
		always_ff @(posedge i_clk or negedge i_resetn) begin
			if (!i_resetn) begin
				o_com[k] <= 1'b0;
			end else if (s2_q[SV_CSR]) begin
				o_com[k] <= (i_com_row == 8'(COM_N - 1 - k));
			end else begin
				o_com[k] <= (i_com_row == 8'(k));
			end
		end
	end

	// Segment shift order
	for (genvar k = 0; k < SEG_N; k++) begin : g_seg
		always_ff @(posedge i_clk or negedge i_resetn) begin
			if (!i_resetn) begin
				o_seg[k] <= 1'b0;
			end else begin
				o_seg[k] <= s2_q[SV_SSR] ? i_seg_data[SEG_N-1-k] : i_seg_data[k];
			end
		end
	end

endmodule
`default_nettype wire

// >>> rtl/lcdhi_pkg.sv
// Shared constants for the LCD driver host link, both ends
package lcdhi_pkg;
	// Link strap levels
	localparam logic LINK_PARALLEL = 1'b0;
	localparam logic LINK_SERIAL   = 1'b1;
	// Direction input levels
	localparam logic DIR_READ  = 1'b1;
	localparam logic DIR_WRITE = 1'b0;
	// Register select codes {hi, lo}
	localparam logic [1:0] SEL_DATA  = 2'h3;
	localparam logic [1:0] SEL_INSTR = 2'h2;
	localparam logic [1:0] SEL_EXPAN = 2'h0;
	// Serial frame: direction, select hi, select lo, then eight data bits
	localparam logic [3:0] SER_HDR_BITS   = 4'h3;
	localparam logic [3:0] SER_FRAME_BITS = 4'hB;
	// Sync vector positions at the device
	localparam int SV_STRAP = 17;
	localparam int SV_RW    = 16;
	localparam int SV_RSH   = 15;
	localparam int SV_RSL   = 14;
	localparam int SV_E     = 13;
	localparam int SV_CSN   = 12;
	localparam int SV_SHT   = 11;
	localparam int SV_SDI   = 10;
	localparam int SV_CSR   = 9;
	localparam int SV_SSR   = 8;
	localparam int SV_W     = 18;
	// Timing
	localparam int CLK_NS      = 25;
	localparam int T_SETUP_NS  = 40;
	localparam int T_EHIGH_NS  = 450;
	localparam int T_ELOW_NS   = 430;
	localparam int T_ECYCLE_NS = 1000;
	localparam int T_SHT_NS    = 200;
	localparam int E_LOW_NS    = (T_ECYCLE_NS - T_EHIGH_NS > T_ELOW_NS) ?
		T_ECYCLE_NS - T_EHIGH_NS : T_ELOW_NS;
	localparam logic [7:0] SETUP_CYC  = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] E_HIGH_CYC = 8'((T_EHIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] E_LOW_CYC  = 8'((E_LOW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] SHT_HALF_CYC = 8'(T_SHT_NS / 2 / CLK_NS);
	// Reset values
	localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage

// >>> rtl/lcdhi_if.sv
// Pin bundle between the LCD driver and its host
`timescale 1ns/1ps
`default_nettype none
interface lcdhi_if;
	logic       strap_serial;
	logic       rw;
	logic       rs_hi;
	logic       rs_lo;
	logic       e;
	logic       cs_n;
	logic       shift_clock;
	logic       sdi;
	logic       sdo;
	logic       common_scan_reverse;
	logic       segment_scan_reverse;
	logic [7:0] bus_h_out;
	logic [7:0] bus_h_oe;
	logic [7:0] bus_d_out;
	logic [7:0] bus_d_oe;
	wire  [7:0] host_bus_lines;
	// Undriven lines float high through the pull-ups
	assign host_bus_lines = (bus_h_out & bus_h_oe) | (bus_d_out & bus_d_oe)
		| ~(bus_h_oe | bus_d_oe);
	modport dev (
		input  strap_serial, rw, rs_hi, rs_lo, e, cs_n, shift_clock, sdi,
		input  common_scan_reverse, segment_scan_reverse, host_bus_lines,
		output sdo, bus_d_out, bus_d_oe
	);
	modport host (
		output strap_serial, rw, rs_hi, rs_lo, e, cs_n, shift_clock, sdi,
		output common_scan_reverse, segment_scan_reverse, bus_h_out, bus_h_oe,
		input  sdo, host_bus_lines
	);
endinterface
`default_nettype wire

// >>> rtl/lcdhi_host.sv
// Host end of the LCD driver link: runs one register transfer per command
`timescale 1ns/1ps
`default_nettype none
module lcdhi_host (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	// Link pins
	lcdhi_if.host           link,
	// Straps
	input  wire logic       i_link_serial,
	input  wire logic       i_nibble_mode,
	input  wire logic       i_com_reverse,
	input  wire logic       i_seg_reverse,
	// Command
	input  wire logic       i_cmd_valid,
	input  wire logic       i_cmd_rw,
	input  wire logic [1:0] i_cmd_sel,
	input  wire logic [7:0] i_cmd_data,
	output logic            o_cmd_ready,
	// Answer
	output logic            o_rd_valid,
	output logic [7:0]      o_rd_data
);
	import lcdhi_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SETUP = 2'b01,
		ST_EHI   = 2'b10,
		ST_ELO   = 2'b11
	} lcdhi_hst_t;

	lcdhi_hst_t  st_q;
	logic        ser_q;
	logic        nib_q;
	logic        second_q;
	logic        ph_q;
	logic [7:0]  tmr_q;
	logic [3:0]  bit_q;
	logic [10:0] sh_q;
	logic [7:0]  data_q;
	logic [7:0]  rd_q;
	logic [7:0]  bus1_q;
	logic [7:0]  bus2_q;
	logic        sdo1_q;
	logic        sdo2_q;
	logic        rw_q;
	logic        rsh_q;
	logic        rsl_q;
	logic        e_q;
	logic        csn_q;
	logic        sht_q;
	logic        sdi_q;
	logic [7:0]  bout_q;
	logic [7:0]  boe_q;
	logic        strap_q;
	logic        csr_q;
	logic        ssr_q;

	// Sample pins from the device
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bus1_q <= 8'hFF;
			bus2_q <= 8'hFF;
			sdo1_q <= 1'b0;
			sdo2_q <= 1'b0;
		end else begin
			bus1_q <= link.host_bus_lines;
			bus2_q <= bus1_q;
			sdo1_q <= link.sdo;
			sdo2_q <= sdo1_q;
		end
	end

	// Straps follow the user levels
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			strap_q <= LINK_PARALLEL;
			csr_q   <= 1'b0;
			ssr_q   <= 1'b0;
		end else begin
			strap_q <= i_link_serial;
			csr_q   <= i_com_reverse;
			ssr_q   <= i_seg_reverse;
		end
	end

	// Transfer sequencer
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_q <= ST_IDLE;
			ser_q <= 1'b0;
			nib_q <= 1'b0;
			second_q <= 1'b0;
			ph_q <= 1'b0;
			tmr_q <= 8'h00;
			bit_q <= 4'h0;
			sh_q <= '0;
			data_q <= BYTE_RESET;
			rd_q <= BYTE_RESET;
			rw_q <= DIR_READ;
			rsh_q <= 1'b1;
			rsl_q <= 1'b1;
			e_q <= 1'b0;
			csn_q <= 1'b1;
			sht_q <= 1'b1;
			sdi_q <= 1'b0;
			bout_q <= 8'hFF;
			boe_q <= 8'h00;
			o_cmd_ready <= 1'b0;
			o_rd_valid <= 1'b0;
			o_rd_data <= BYTE_RESET;
		end else begin
			o_rd_valid <= 1'b0;
			if (tmr_q != 8'h00) begin
				tmr_q <= tmr_q - 8'h01;
			end
			unique case (st_q)
				ST_IDLE: begin
					o_cmd_ready <= 1'b1;
					if (i_cmd_valid && o_cmd_ready) begin
						o_cmd_ready <= 1'b0;
						ser_q <= strap_q;
						nib_q <= i_nibble_mode;
						second_q <= 1'b0;
						data_q <= i_cmd_data;
						rw_q <= i_cmd_rw;
						rsh_q <= i_cmd_sel[1];
						rsl_q <= i_cmd_sel[0];
						sh_q <= {i_cmd_rw, i_cmd_sel, i_cmd_data};
						bit_q <= 4'h0;
						ph_q <= 1'b0;
						if (strap_q == LINK_SERIAL) begin
							csn_q <= 1'b0;
							tmr_q <= SHT_HALF_CYC;
							st_q <= ST_EHI;
						end else begin
							bout_q <= i_cmd_data;
							boe_q <= (i_cmd_rw == DIR_READ) ? 8'h00 :
								(i_nibble_mode ? 8'hF0 : 8'hFF);
							tmr_q <= SETUP_CYC;
							st_q <= ST_SETUP;
						end
					end
				end
				ST_SETUP: begin
					if (tmr_q == 8'h00) begin
						e_q <= 1'b1;
						tmr_q <= E_HIGH_CYC;
						st_q <= ST_EHI;
					end
				end
				ST_EHI: begin
					if (tmr_q == 8'h00 && ser_q) begin
						tmr_q <= SHT_HALF_CYC;
						ph_q <= !ph_q;
						if (ph_q) begin
							sht_q <= 1'b1;
							bit_q <= bit_q + 4'h1;
						end else begin
							if (bit_q > SER_HDR_BITS) begin
								rd_q <= {rd_q[6:0], sdo2_q};
							end
							if (bit_q == SER_FRAME_BITS) begin
								csn_q <= 1'b1;
								o_rd_data <= {rd_q[6:0], sdo2_q};
								o_rd_valid <= (rw_q == DIR_READ);
								st_q <= ST_IDLE;
							end else begin
								sht_q <= 1'b0;
								sdi_q <= sh_q[10];
								sh_q <= {sh_q[9:0], 1'b0};
							end
						end
					end else if (tmr_q == 8'h00) begin
						e_q <= 1'b0;
						rd_q <= second_q ? {rd_q[7:4], bus2_q[7:4]} :
							(nib_q ? {bus2_q[7:4], 4'h0} : bus2_q);
						tmr_q <= E_LOW_CYC;
						st_q <= ST_ELO;
					end
				end
				ST_ELO: begin
					if (tmr_q == 8'h00) begin
						if (nib_q && !second_q) begin
							second_q <= 1'b1;
							bout_q <= {data_q[3:0], 4'h0};
							tmr_q <= SETUP_CYC;
							st_q <= ST_SETUP;
						end else begin
							boe_q <= 8'h00;
							o_rd_data <= rd_q;
							o_rd_valid <= (rw_q == DIR_READ);
							st_q <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	assign link.strap_serial = strap_q;
	assign link.rw = rw_q;
	assign link.rs_hi = rsh_q;
	assign link.rs_lo = rsl_q;
	assign link.e = e_q;
	assign link.cs_n = csn_q;
	assign link.shift_clock = sht_q;
	assign link.sdi = sdi_q;
	assign link.common_scan_reverse = csr_q;
	assign link.segment_scan_reverse = ssr_q;
	assign link.bus_h_out = bout_q;
	assign link.bus_h_oe = boe_q;

endmodule
`default_nettype wire

// >>> tb/lcdhi_link_asserts.sv
// Protocol checks on the pins between the LCD driver and its host
`timescale 1ns/1ps
`default_nettype none
module lcdhi_link_asserts
	import lcdhi_pkg::*;
(
	// Clock and reset
	input wire logic       i_clk,
	input wire logic       i_resetn,
	// Link pins
	input wire logic       strap_serial,
	input wire logic       rw,
	input wire logic       rs_hi,
	input wire logic       rs_lo,
	input wire logic       e,
	input wire logic       cs_n,
	input wire logic       shift_clock,
	input wire logic       sdi,
	input wire logic       sdo,
	input wire logic [7:0] bus_h_out,
	input wire logic [7:0] bus_h_oe,
	input wire logic [7:0] bus_d_oe
);
	logic [7:0] e_cnt_q;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	// Counts how long the strobe has been high
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			e_cnt_q <= 8'h00;
		end else if (e) begin
			e_cnt_q <= e_cnt_q + 8'h01;
		end else begin
			e_cnt_q <= 8'h00;
		end
	end

	property p_ser_no_strobe;
		strap_serial |-> !e;
	endproperty
	a_ser_no_strobe: assert property (p_ser_no_strobe)
		else $error("strobe raised in serial mode");
	property p_par_ser_idle;
		!strap_serial |-> cs_n && shift_clock;
	endproperty
	a_par_ser_idle: assert property (p_par_ser_idle)
		else $error("serial pins active in parallel mode");
	property p_ser_bus_free;
		strap_serial |-> !(|bus_h_oe) && !(|bus_d_oe);
	endproperty
	a_ser_bus_free: assert property (p_ser_bus_free)
		else $error("bus driven in serial mode");
	property p_dev_drive_read;
		|bus_d_oe |-> rw && !(|bus_h_oe);
	endproperty
	a_dev_drive_read: assert property (p_dev_drive_read)
		else $error("device drives bus outside a read");
	property p_host_drive_write;
		|bus_h_oe |-> !rw;
	endproperty
	a_host_drive_write: assert property (p_host_drive_write)
		else $error("host drives bus outside a write");
	// strobe width, timer reload cycle included
	property p_strobe_width;
		$fell(e) |-> e_cnt_q == E_HIGH_CYC + 8'h01;
	endproperty
	a_strobe_width: assert property (p_strobe_width)
		else $error("strobe high time wrong");
	property p_sel_hold;
		$fell(e) |-> $stable({rw, rs_hi, rs_lo}) [*3];
	endproperty
	a_sel_hold: assert property (p_sel_hold)
		else $error("select moved right after strobe");
	property p_wdata_hold;
		$fell(e) && !rw |-> $stable(bus_h_out) [*3] ##0 (&bus_h_oe[7:4]);
	endproperty
	a_wdata_hold: assert property (p_wdata_hold)
		else $error("write data moved right after strobe");
	property p_sdi_at_fall;
		!cs_n && !$past(cs_n) && $changed(sdi) |-> !shift_clock;
	endproperty
	a_sdi_at_fall: assert property (p_sdi_at_fall)
		else $error("serial input moved while shift clock high");
	property p_sdo_at_fall;
		!cs_n && $changed(sdo) |-> !shift_clock || !$past(shift_clock);
	endproperty
	a_sdo_at_fall: assert property (p_sdo_at_fall)
		else $error("serial output moved away from a falling edge");
	property p_desel_idle;
		cs_n |-> shift_clock;
	endproperty
	a_desel_idle: assert property (p_desel_idle)
		else $error("shift clock moved while deselected");
endmodule
`default_nettype wire

// >>> tb/lcdhi_tb.sv
// Both ends of the LCD driver link joined and driven from their user sides
`timescale 1ns/1ps
`default_nettype none
module lcdhi_tb;
	import lcdhi_pkg::*;
	typedef struct packed {
		logic       ser;
		logic       nib;
		logic       rw;
		logic [1:0] sel;
		logic [7:0] val;
	} lcdhi_row_t;

	logic             i_clk = 1'b0;
	logic             i_resetn = 1'b0;
	logic             link_ser = 1'b0, nib = 1'b0, com_rev = 1'b0, seg_rev = 1'b0;
	logic             cmd_valid = 1'b0, cmd_rw = 1'b0;
	logic [1:0]       cmd_sel = 2'h0;
	logic [7:0]       cmd_data = 8'h00, rd_data = 8'h00, com_row = 8'h00;
	logic [99:0]      seg = 100'h9_0123_4567_89AB_CDEF_0F1E_2D3C;
	logic [3:0][7:0]  rd_tab = {8'h6E, 8'h81, 8'h00, 8'h17};
	logic             o_cmd_ready, o_rd_valid, o_serial_mode, o_wr_valid, o_rd_taken;
	logic [7:0]       o_rd_data, o_wr_data;
	logic [1:0]       o_wr_sel, o_rd_sel;
	logic [16:0]      o_com;
	logic [99:0]      o_seg;
	logic             lo_drv = 1'b0;
	int               num_errors = 0, num_checks = 0;
	int               wr_cnt = 0, rdv_cnt = 0, taken_cnt = 0;
	lcdhi_row_t       rows [10];

	lcdhi_if i_lcdhi_if ();
	lcdhi_host i_lcdhi_host (.i_clk(i_clk), .i_resetn(i_resetn), .link(i_lcdhi_if),
		.i_link_serial(link_ser), .i_nibble_mode(nib), .i_com_reverse(com_rev),
		.i_seg_reverse(seg_rev), .i_cmd_valid(cmd_valid), .i_cmd_rw(cmd_rw),
		.i_cmd_sel(cmd_sel), .i_cmd_data(cmd_data), .o_cmd_ready(o_cmd_ready),
		.o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data));
	lcdhi_device #(.COM_N(17), .SEG_N(100)) i_lcdhi_device (.i_clk(i_clk),
		.i_resetn(i_resetn), .link(i_lcdhi_if), .i_nibble_mode(nib),
		.o_serial_mode(o_serial_mode), .o_wr_valid(o_wr_valid), .o_wr_sel(o_wr_sel),
		.o_wr_data(o_wr_data), .o_rd_sel(o_rd_sel), .o_rd_taken(o_rd_taken),
		.i_rd_data(rd_data), .i_com_row(com_row), .i_seg_data(seg), .o_com(o_com),
		.o_seg(o_seg));
	lcdhi_link_asserts i_lcdhi_link_asserts (.i_clk(i_clk), .i_resetn(i_resetn),
		.strap_serial(i_lcdhi_if.strap_serial), .rw(i_lcdhi_if.rw),
		.rs_hi(i_lcdhi_if.rs_hi), .rs_lo(i_lcdhi_if.rs_lo), .e(i_lcdhi_if.e),
		.cs_n(i_lcdhi_if.cs_n), .shift_clock(i_lcdhi_if.shift_clock),
		.sdi(i_lcdhi_if.sdi), .sdo(i_lcdhi_if.sdo), .bus_h_out(i_lcdhi_if.bus_h_out),
		.bus_h_oe(i_lcdhi_if.bus_h_oe), .bus_d_oe(i_lcdhi_if.bus_d_oe));

	always #12.5 i_clk = ~i_clk;

	// Register file answers for the register being read
	always @(posedge i_clk) begin
		rd_data <= rd_tab[o_rd_sel];
		if (o_wr_valid === 1'b1) wr_cnt++;
		if (o_rd_valid === 1'b1) rdv_cnt++;
		if (o_rd_taken === 1'b1) taken_cnt++;
		if (nib === 1'b1 && |i_lcdhi_if.bus_d_oe[3:0]) lo_drv = 1'b1;
	end

	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		while (o_cmd_ready !== 1'b1 && n < 400) begin
			@(posedge i_clk);
			n++;
		end
	endtask

	task automatic issue(input logic rw, input logic [1:0] sel, input logic [7:0] d);
		wait_ready();
		cmd_valid <= 1'b1;
		cmd_rw <= rw;
		cmd_sel <= sel;
		cmd_data <= d;
		@(posedge i_clk);
		cmd_valid <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic run_row(input int r);
		lcdhi_row_t w;
		w = rows[r];
		link_ser <= w.ser;
		nib <= w.nib;
		repeat (5) @(posedge i_clk);
		wr_cnt = 0;
		rdv_cnt = 0;
		taken_cnt = 0;
		issue(w.rw, w.sel, w.val);
		wait_ready();
		repeat (6) @(posedge i_clk);
		chk(o_cmd_ready, 1'b1);
		chk(o_serial_mode, w.ser);
		chk(wr_cnt, w.rw == DIR_WRITE);
		chk(rdv_cnt, w.rw == DIR_READ);
		chk(taken_cnt, w.rw == DIR_READ);
		if (w.rw == DIR_WRITE) begin
			chk(o_wr_sel, w.sel);
			chk(o_wr_data, w.val);
		end else begin
			chk(o_rd_data, w.val);
		end
		if (w.ser) chk(i_lcdhi_if.host_bus_lines, 8'hFF);
		$display("row %0d done", r);
	endtask

	initial begin
		#500000;
		num_errors++;
		finish_test();
	end

	initial begin
		rows = '{
			'{1'b0, 1'b0, DIR_WRITE, SEL_DATA,  8'hA5},
			'{1'b0, 1'b0, DIR_READ,  SEL_INSTR, 8'h81},
			'{1'b0, 1'b0, DIR_WRITE, SEL_EXPAN, 8'h01},
			'{1'b0, 1'b1, DIR_WRITE, SEL_DATA,  8'hC3},
			'{1'b0, 1'b1, DIR_READ,  SEL_DATA,  8'h6E},
			'{1'b0, 1'b1, DIR_READ,  SEL_EXPAN, 8'h17},
			'{1'b1, 1'b0, DIR_WRITE, SEL_INSTR, 8'h5A},
			'{1'b1, 1'b0, DIR_READ,  SEL_DATA,  8'h6E},
			'{1'b1, 1'b0, DIR_WRITE, SEL_DATA,  8'h80},
			'{1'b1, 1'b0, DIR_READ,  SEL_EXPAN, 8'h17}};
		repeat (4) @(posedge i_clk);
		i_resetn <= 1'b1;
		for (int r = 0; r < 10; r++) run_row(r);
		chk(lo_drv, 1'b0);
		// Scan order straps, both directions, middle and edge rows
		com_row <= 8'h05;
		repeat (6) @(posedge i_clk);
		chk(o_com, 17'h00020);
		chk(o_seg, seg);
		com_rev <= 1'b1;
		seg_rev <= 1'b1;
		com_row <= 8'h10;
		repeat (6) @(posedge i_clk);
		chk(o_com, 17'h00001);
		chk(o_seg, {<<{seg}});
		$display("scan test done");
		// Reset cuts a serial write short
		link_ser <= 1'b1;
		repeat (5) @(posedge i_clk);
		wr_cnt = 0;
		issue(DIR_WRITE, SEL_DATA, 8'h77);
		repeat (20) @(posedge i_clk);
		i_resetn <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk(o_cmd_ready, 1'b0);
		chk(i_lcdhi_if.e, 1'b0);
		chk(i_lcdhi_if.cs_n, 1'b1);
		chk(i_lcdhi_if.shift_clock, 1'b1);
		chk(o_wr_valid, 1'b0);
		i_resetn <= 1'b1;
		repeat (40) @(posedge i_clk);
		chk(wr_cnt, 0);
		$display("reset test done");
		run_row(6);
		finish_test();
	end
endmodule
`default_nettype wire
